// [core/positioner_status_registers.sv]
/*
  Status register bank of the positioning drive: flags, speed, position,
  torque with peak capture, supplies, temperature, build date and serial.
  Assumes a front end that delivers one register access per request and
  motion logic on the same clock that supplies measurements and steps.
*/
`timescale 1ns/10ps

module positioner_status_registers
  import positioner_status_pkg::*;
#(
  parameter logic [15:0] YEAR_WEEK_CODE = 16'h0000, // arbitrary value
  parameter logic [15:0] SERIAL_NUMBER  = 16'h0000  // arbitrary value
)
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire reg_req_s     regReq,
  output reg_rsp_s          regRsp,
  input  wire drive_flags_s flagsIn,
  input  wire logic         revJogKey,
  input  wire logic         fwdJogKey,
  input  wire run_phase_s   runPhase,
  input  wire logic         posStep,
  input  wire logic         posStepDown,
  input  wire logic [15:0]  speedRpm,
  input  wire logic [15:0]  torqueNow,
  input  wire logic [15:0]  logicSupply,
  input  wire logic [15:0]  driveSupply,
  input  wire logic [15:0]  tempCelsius,
  output logic [31:0]       position
);

  logic [1:0]   jogKeys;
  logic [2:0]   jogSync  [2];
  logic         jogState [2];
  drive_flags_s flagWord;
  drive_flags_s driveFlags;
  logic [15:0]  shaftSpeed;
  logic [15:0]  presentTorque;
  logic [15:0]  peakRunTorque;
  logic [15:0]  logicSupplyVolts;
  logic [15:0]  driveSupplyVolts;
  logic [15:0]  internalTemp;
  logic [15:0]  upperHold;
  logic         upperArmed;
  logic         wasRunning;
  logic         isWrite;
  logic         isRead;
  logic         lowerOk;
  logic         posLoad;
  logic [15:0]  rdWord;
  logic [7:0]   next_result;

  // both jog keys in one bus, reverse key on bit 0
  assign jogKeys = {fwdJogKey, revJogKey};

  // jog key pins pass three flops; a change counts once the last two agree,
  // so a single glitch on a key never reaches the status word
  for (genvar k = 0; k < 2; k++)
  begin : g_jog
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        jogSync[k]  <= 3'h0;
        jogState[k] <= 1'b0;
      end
      else if (ce)
      begin
        jogSync[k] <= {jogSync[k][1:0], jogKeys[k]};
        if (jogSync[k][2] == jogSync[k][1])
          jogState[k] <= jogSync[k][2];
      end
    end
  end

  // status word with the jog bits taken from the synchronised keys
  always_comb
  begin
    flagWord        = flagsIn;
    flagWord.revJog = jogState[0];
    flagWord.fwdJog = jogState[1];
  end

  // status word and live measurements sampled every cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      driveFlags       <= '0;
      shaftSpeed       <= WORD_RESET;
      presentTorque    <= WORD_RESET;
      logicSupplyVolts <= WORD_RESET;
      driveSupplyVolts <= WORD_RESET;
      internalTemp     <= WORD_RESET;
    end
    else if (ce)
    begin
      driveFlags        <= flagWord;
      shaftSpeed        <= speedRpm;
      presentTorque     <= torqueNow;
      logicSupplyVolts  <= logicSupply;
      driveSupplyVolts  <= driveSupply;
      internalTemp      <= tempCelsius;
    end
  end

  // peak torque: cleared at run start, captured outside start and braking
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      peakRunTorque <= WORD_RESET;
      wasRunning    <= 1'b0;
    end
    else if (ce)
    begin
      wasRunning <= runPhase.running;
      if (runPhase.running && !wasRunning)
        peakRunTorque <= WORD_RESET;
      else if (runPhase.running && !runPhase.startPhase && !runPhase.braking
               && torqueNow > peakRunTorque)
        peakRunTorque <= torqueNow;
    end
  end

  // request decode
  assign isRead  = regReq.valid && regReq.func == FC_READ_HOLDING;
  assign isWrite = regReq.valid
                   && (regReq.func == FC_WRITE_SINGLE || regReq.func == FC_WRITE_MULTI);
  assign lowerOk = upperArmed && regReq.addr == POSITION_LOWER_ADDR;
  assign posLoad = isWrite && lowerOk;

  // high word is held until the matching low word arrives; any other
  // in-range write disarms the pair so a stale high word is never used
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      upperHold  <= WORD_RESET;
      upperArmed <= 1'b0;
    end
    else if (ce && isWrite && regReq.addr < ADDR_LIMIT)
    begin
      upperArmed <= regReq.addr == POSITION_UPPER_ADDR;
      if (regReq.addr == POSITION_UPPER_ADDR)
        upperHold <= regReq.data;
    end
  end

  // position counter: re-referenced on low write, else follows steps;
  // a load beats a step in the same cycle so the written value is exact
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      position <= POSITION_RESET;
    else if (ce)
    begin
      if (posLoad)
        position <= {upperHold, regReq.data};
      else if (posStep && posStepDown)
        position <= position - 32'h0000_0001;
      else if (posStep)
        position <= position + 32'h0000_0001;
    end
  end

  // read multiplexer, unlisted addresses read zero
  always_comb
  begin
    unique case (regReq.addr)
      DRIVE_FLAGS_ADDR:        rdWord = driveFlags;
      SHAFT_SPEED_ADDR:        rdWord = shaftSpeed;
      POSITION_UPPER_ADDR:     rdWord = position[31:16];
      POSITION_LOWER_ADDR:     rdWord = position[15:0];
      PRESENT_TORQUE_ADDR:     rdWord = presentTorque;
      PEAK_RUN_TORQUE_ADDR:    rdWord = peakRunTorque;
      LOGIC_SUPPLY_VOLTS_ADDR: rdWord = logicSupplyVolts;
      DRIVE_SUPPLY_VOLTS_ADDR: rdWord = driveSupplyVolts;
      INTERNAL_TEMP_ADDR:      rdWord = internalTemp;
      BUILD_DATE_ADDR:         rdWord = YEAR_WEEK_CODE;
      UNIT_SERIAL_ADDR:        rdWord = SERIAL_NUMBER;
      default:                 rdWord = WORD_RESET;
    endcase
  end

  // result code for the current request
  // reserved words accept writes silently and read back as zero
  always_comb
  begin
    next_result = RES_IDLE;
    if (!isRead && !isWrite)
      next_result = RES_ILLEGAL_FUNC;
    else if (regReq.addr >= ADDR_LIMIT)
      next_result = RES_ILLEGAL_ADDR;
    else if (isWrite && regReq.addr == POSITION_LOWER_ADDR && !lowerOk)
      next_result = RES_DEVICE_FAIL;
    else if (isWrite && regReq.addr != POSITION_UPPER_ADDR
             && regReq.addr != POSITION_LOWER_ADDR
             && (regReq.addr <= INTERNAL_TEMP_ADDR
                 || regReq.addr == BUILD_DATE_ADDR
                 || regReq.addr == UNIT_SERIAL_ADDR))
      next_result = RES_ILLEGAL_ADDR;    // read-only words refuse writes
  end

  // registered answer, one cycle after the request
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      regRsp <= '0;
    else if (ce)
    begin
      regRsp.valid  <= regReq.valid;
      regRsp.result <= next_result;
      regRsp.data   <= (isRead && next_result == RES_IDLE) ? rdWord : WORD_RESET;
    end
  end

endmodule

// [include/positioner_status_pkg.sv]
/*
  Constants, field layouts and carrier types for the positioner status bank.
  Assumes a register front end that turns bus frames into single-register requests.
*/
package positioner_status_pkg;

  // register offsets
  localparam logic [15:0] DRIVE_FLAGS_ADDR        = 16'h0000;
  localparam logic [15:0] SHAFT_SPEED_ADDR        = 16'h0001;
  localparam logic [15:0] POSITION_UPPER_ADDR     = 16'h0002;
  localparam logic [15:0] POSITION_LOWER_ADDR     = 16'h0003;
  localparam logic [15:0] PRESENT_TORQUE_ADDR     = 16'h0004;
  localparam logic [15:0] PEAK_RUN_TORQUE_ADDR    = 16'h0005;
  localparam logic [15:0] LOGIC_SUPPLY_VOLTS_ADDR = 16'h0006;
  localparam logic [15:0] DRIVE_SUPPLY_VOLTS_ADDR = 16'h0007;
  localparam logic [15:0] INTERNAL_TEMP_ADDR      = 16'h0008;
  localparam logic [15:0] BUILD_DATE_ADDR         = 16'h000c;
  localparam logic [15:0] UNIT_SERIAL_ADDR        = 16'h000d;
  localparam logic [15:0] ADDR_LIMIT              = 16'h0100;

  // bus function codes
  localparam logic [7:0] FC_READ_HOLDING  = 8'h03;
  localparam logic [7:0] FC_WRITE_SINGLE  = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI   = 8'h10;

  // result codes
  localparam logic [7:0] RES_IDLE          = 8'h00;
  localparam logic [7:0] RES_ILLEGAL_FUNC  = 8'h01;
  localparam logic [7:0] RES_ILLEGAL_ADDR  = 8'h02;
  localparam logic [7:0] RES_DEVICE_FAIL   = 8'h04;

  // reset values
  localparam logic [31:0] POSITION_RESET   = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET       = 16'h0000;

  // status word, bit 15 down to bit 0
  typedef struct packed {
    logic negLimit;        // bit 15
    logic posLimit;        // bit 14
    logic lostPower;       // bit 13
    logic badTarget;       // bit 12
    logic manualMove;      // bit 11
    logic blockError;      // bit 10
    logic generalError;    // bit 9
    logic againstLoop;     // bit 8
    logic overTemp;        // bit 7
    logic running;         // bit 6
    logic runAborted;      // bit 5
    logic motorPower;      // bit 4
    logic fwdJog;          // bit 3
    logic revJog;          // bit 2
    logic followError;     // bit 1
    logic targetReached;   // bit 0
  } drive_flags_s;

  // one register request from the front end
  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } reg_req_s;

  // answer to one request
  typedef struct packed {
    logic        valid;
    logic [7:0]  result;
    logic [15:0] data;
  } reg_rsp_s;

  // run phases fed from motion control
  typedef struct packed {
    logic running;
    logic startPhase;
    logic braking;
  } run_phase_s;

endpackage

// [sim/positioner_master_model.sv]
/* bus master model: single requests and high-then-low pair writes
   assumes the bank answers one cycle after taking a request */
`timescale 1ns/10ps
module positioner_master_model
  import positioner_status_pkg::*;
(
  input  wire logic     clk,
  input  wire reg_rsp_s regRsp,
  output reg_req_s      regReq
);
  initial regReq = '0;
  // one request held for one edge, answer taken at the next
  task automatic access(input logic [7:0] func, input logic [15:0] addr,
                        input logic [15:0] data, output reg_rsp_s rsp);
    @(posedge clk);
    regReq <= '{1'b1, func, addr, data};
    @(posedge clk);
    regReq <= '{1'b0, ~func, ~addr, ~data}; // released lines toggle
    @(posedge clk);
    rsp = regRsp;
  endtask
  // upper word then lower word back to back
  task automatic pair(input logic [31:0] value, output reg_rsp_s hiRsp, output reg_rsp_s loRsp);
    @(posedge clk);
    regReq <= '{1'b1, FC_WRITE_SINGLE, POSITION_UPPER_ADDR, value[31:16]};
    @(posedge clk);
    regReq <= '{1'b1, FC_WRITE_SINGLE, POSITION_LOWER_ADDR, value[15:0]};
    @(posedge clk);
    regReq <= '{1'b0, 8'hf9, 16'hfffc, ~value[15:0]};
    hiRsp = regRsp;
    @(posedge clk);
    loRsp = regRsp;
  endtask
endmodule

// [sim/positioner_status_properties.sv]
/* port checker for the status bank
   assumes binding to the bank, one clock, ce as the bank sees it */
`timescale 1ns/10ps
module positioner_status_properties
  import positioner_status_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        ce,
  input wire reg_req_s    regReq,
  input wire reg_rsp_s    regRsp,
  input wire logic        posStep,
  input wire logic        posStepDown,
  input wire logic [31:0] position
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // request decode
  wire take  = ce && regReq.valid;
  wire wr    = take && regReq.func inside {FC_WRITE_SINGLE, FC_WRITE_MULTI};
  wire rd    = take && regReq.func == FC_READ_HOLDING;
  wire hi    = regReq.addr == POSITION_UPPER_ADDR;
  wire lo    = regReq.addr == POSITION_LOWER_ADDR;
  wire spare = regReq.addr inside {[16'h0009:16'h000b], [16'h000e:16'h00ff]};
  // latest in-range write went to the upper word
  logic upperLast;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      upperLast <= 1'b0;
    else if (wr && regReq.addr < ADDR_LIMIT)
      upperLast <= hi;
  end
  a_answer_next: assert property (
    take |=> regRsp.valid) else $error("request not answered");
  a_bad_func: assert property (
    take && !wr && !rd |=> regRsp.result == RES_ILLEGAL_FUNC) else $error("bad function taken");
  a_spare_zero: assert property (
    rd && spare |=> regRsp.data == 16'h0000) else $error("spare word not zero");
  a_far_addr: assert property (
    rd && regReq.addr >= ADDR_LIMIT |=> regRsp.result == RES_ILLEGAL_ADDR) else $error("far read");
  a_pair_load: assert property (
    wr && hi ##1 wr && lo |=> position == {$past(regReq.data, 2), $past(regReq.data)})
    else $error("pair not loaded");
  a_lone_low: assert property (
    wr && lo && !upperLast && !posStep |=> regRsp.result == RES_DEVICE_FAIL && $stable(position))
    else $error("lone low write taken");
  a_step_count: assert property (
    ce && posStep && !(wr && lo)
    |=> position == $past(position) + ($past(posStepDown) ? 32'hffff_ffff : 32'h1))
    else $error("step miscounted");
  a_pos_hold: assert property (
    ce && !posStep && !wr |=> $stable(position)) else $error("position drifted");
  a_ce_freeze: assert property (
    !ce |=> $stable(position) && $stable(regRsp)) else $error("state moved with ce low");
  c_pair: cover property (wr && hi ##1 wr && lo);
  c_step: cover property (ce && posStep);
  c_lone: cover property (wr && lo && !upperLast);
  c_freeze: cover property (!ce ##1 !ce);
endmodule
bind positioner_status_registers positioner_status_properties props (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .regReq(regReq), .regRsp(regRsp),
  .posStep(posStep), .posStepDown(posStepDown), .position(position));

// [sim/positioner_status_registers_tb.sv]
/* bench of the status bank: measurement stimulus and register checks
   assumes the master model carries all register traffic */
`timescale 1ns/10ps
`define CHK(what, exp, got) \
  begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module positioner_status_registers_tb
  import positioner_status_pkg::*;
;
  logic         clk = 1'b0;
  logic         sys_rst, ce, revJogKey, fwdJogKey, posStep, posStepDown;
  logic [15:0]  speedRpm, torqueNow, logicSupply, driveSupply, tempCelsius;
  drive_flags_s flagsIn;
  run_phase_s   runPhase;
  reg_req_s     regReq;
  reg_rsp_s     regRsp, rsp, rspLow;
  logic [31:0]  position;
  logic [15:0]  spare [5] = '{16'h0009, 16'h000a, 16'h000b, 16'h000e, 16'h00ff};
  int           mismatches = 0;
  int           checked = 0;
  int           cycles = 0;
  positioner_status_registers #(.YEAR_WEEK_CODE(16'h2417), .SERIAL_NUMBER(16'h0b57)) DUT (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .regReq(regReq), .regRsp(regRsp),
    .flagsIn(flagsIn), .revJogKey(revJogKey), .fwdJogKey(fwdJogKey), .runPhase(runPhase),
    .posStep(posStep), .posStepDown(posStepDown), .speedRpm(speedRpm), .torqueNow(torqueNow),
    .logicSupply(logicSupply), .driveSupply(driveSupply), .tempCelsius(tempCelsius),
    .position(position));
  positioner_master_model m (.clk(clk), .regRsp(regRsp), .regReq(regReq));
  // one access with its result code
  task automatic req(input logic [7:0] func, input logic [15:0] addr, input logic [15:0] data,
                     input logic [7:0] res);
    m.access(func, addr, data, rsp);
    `CHK("valid", 1'b1, rsp.valid)
    `CHK("result", res, rsp.result)
  endtask
  task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
    req(FC_READ_HOLDING, addr, 16'h0000, RES_IDLE);
    `CHK("read data", exp, rsp.data)
  endtask
  task automatic drive(input run_phase_s ph, input logic [15:0] tq);
    @(posedge clk);
    runPhase <= ph;
    torqueNow <= tq;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run;
    end
  end
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    flagsIn = 16'hc3f3;
    {revJogKey, fwdJogKey, posStep, posStepDown, runPhase} = 7'h00;
    {speedRpm, torqueNow, logicSupply} = {16'hff38, 16'h01f4, 16'h00f0};
    {driveSupply, tempCelsius} = {16'h01e0, 16'hfffb};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    revJogKey <= 1'b1;
    repeat (6) @(posedge clk);
    rd(DRIVE_FLAGS_ADDR, 16'hc3f7);
    revJogKey <= 1'b0;
    fwdJogKey <= 1'b1;
    repeat (6) @(posedge clk);
    rd(DRIVE_FLAGS_ADDR, 16'hc3fb);
    rd(SHAFT_SPEED_ADDR, 16'hff38);
    rd(PRESENT_TORQUE_ADDR, 16'h01f4);
    rd(LOGIC_SUPPLY_VOLTS_ADDR, 16'h00f0);
    rd(DRIVE_SUPPLY_VOLTS_ADDR, 16'h01e0);
    req(FC_WRITE_SINGLE, INTERNAL_TEMP_ADDR, 16'h0000, RES_ILLEGAL_ADDR);
    rd(INTERNAL_TEMP_ADDR, 16'hfffb);
    rd(BUILD_DATE_ADDR, 16'h2417);
    rd(UNIT_SERIAL_ADDR, 16'h0b57);
    foreach (spare[i])
      rd(spare[i], 16'h0000);
    req(FC_WRITE_MULTI, 16'h000a, 16'h0000, RES_IDLE);
    req(FC_READ_HOLDING, ADDR_LIMIT, 16'h0000, RES_ILLEGAL_ADDR);
    req(8'h2b, DRIVE_FLAGS_ADDR, 16'h0000, RES_ILLEGAL_FUNC);
    m.pair(32'hfffe_1234, rsp, rspLow);
    `CHK("pair results", 16'h0000, {rsp.result, rspLow.result})
    `CHK("position", 32'hfffe_1234, position)
    posStepDown <= 1'b1;
    posStep <= 1'b1;
    @(posedge clk);
    posStep <= 1'b0;
    rd(POSITION_UPPER_ADDR, 16'hfffe);
    rd(POSITION_LOWER_ADDR, 16'h1233);
    req(FC_WRITE_SINGLE, POSITION_UPPER_ADDR, 16'h0000, RES_IDLE);
    req(FC_WRITE_SINGLE, 16'h0009, 16'h0000, RES_IDLE);
    req(FC_WRITE_SINGLE, POSITION_LOWER_ADDR, 16'h0000, RES_DEVICE_FAIL);
    `CHK("position kept", 32'hfffe_1233, position)
    drive(3'b110, 16'h0384);
    drive(3'b100, 16'h012c);
    drive(3'b100, 16'h01f4);
    drive(3'b101, 16'h0320);
    drive(3'b000, 16'h0064);
    rd(PEAK_RUN_TORQUE_ADDR, 16'h01f4);
    drive(3'b100, 16'h00c8);
    drive(3'b100, 16'h00c8);
    drive(3'b000, 16'h0064);
    rd(PEAK_RUN_TORQUE_ADDR, 16'h00c8);
    // clock enable low freezes the counter despite steps
    ce <= 1'b0;
    posStep <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("frozen position", 32'hfffe_1233, position)
    ce <= 1'b1;
    posStep <= 1'b0;
    // mid-run reset clears counter and peak
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK("reset position", 32'h0000_0000, position)
    rd(PEAK_RUN_TORQUE_ADDR, 16'h0000);
    rd(POSITION_UPPER_ADDR, 16'h0000);
    complete_run;
  end
endmodule
